// ---- pkg/aks_defines.vh ----
// Purpose: constants for the per-level address key register and key selection
// Assumes: 32-bit AHB-Lite register bus, four priority levels, 3-bit address keys
// Notes:   bit 15 of a key register is the operand-space-merge bit
`ifndef AKS_DEFINES_VH
`define AKS_DEFINES_VH

// register byte offsets
`define AKS_OFF_LEVEL0      8'h00
`define AKS_OFF_LEVEL1      8'h04
`define AKS_OFF_LEVEL2      8'h08
`define AKS_OFF_LEVEL3      8'h0C
`define AKS_OFF_SAR_KEY     8'h10
`define AKS_OFF_SOA_KEY     8'h14
`define AKS_OFF_CTRL        8'h18
`define AKS_OFF_STATUS      8'h1C

// key register field layout
`define AKS_MERGE_BIT       15
`define AKS_OP1_HI          10
`define AKS_OP1_LO          8
`define AKS_OP2_HI          6
`define AKS_OP2_LO          4
`define AKS_ISK_HI          2
`define AKS_ISK_LO          0
`define AKS_KEYREG_MASK     16'h8777
`define AKS_KEYREG_RESET    16'h0000
`define AKS_KEY_ZERO        3'h0

// access types presented by the sequencer
`define AKS_ACC_FETCH       4'h0
`define AKS_ACC_APPENDED    4'h1
`define AKS_ACC_OPND1       4'h2
`define AKS_ACC_OPND2       4'h3
`define AKS_ACC_INDIRECT    4'h4
`define AKS_ACC_DPT_WRITE   4'h5
`define AKS_ACC_CYCSTEAL    4'h6
`define AKS_ACC_DCB_FETCH   4'h7
`define AKS_ACC_CONSOLE     4'h8
`define AKS_ACC_STOP_CMP    4'h9
`define AKS_ACC_LSB_STORE   4'hA

// interrupt kinds
`define AKS_INT_PRIORITY    3'h0
`define AKS_INT_SVC         3'h1
`define AKS_INT_MCHECK      3'h2
`define AKS_INT_PCHECK      3'h3
`define AKS_INT_SOFTEXC     3'h4
`define AKS_INT_TRACE       3'h5
`define AKS_INT_CONSOLE     3'h6
`define AKS_INT_POWER       3'h7

// key-related instructions
`define AKS_OP_ENABLE       2'h0
`define AKS_OP_DISABLE      2'h1
`define AKS_OP_LOAD_BLOCK   2'h2
`define AKS_OP_LOAD_KEYREG  2'h3

`endif

// ---- hdl/aks_key_select.v ----
// Purpose: per-level key registers and active address key selection for the translator
// Assumes: one clock, synchronous active-high reset, sequencer inputs synchronous to clk
// Notes:   every bus transfer takes one wait state; access answers come one cycle later
//
// Notes on behaviour
// - merge bit set: every data operand access uses the second operand key
// - key register holds first, second and instruction keys, low bits 8, 4, 0
// - merge set: first operand key ignored but kept; its accesses use second key
// - merge clear: first operand key is active for its own accesses
// - merge set by enable, level-block, key-register load; cleared by disable, loads
// - priority or class interrupt clears the merge bit of that level
// - instruction fetches use the instruction space key
// - storage-to-storage operand 1 reads and writes use first key if merge clear
// - other data accesses, not branch or jump, use the second operand key
// - cycle steal uses the control block key; control block fetch uses key 0
// - direct program transfer writes into storage use the second operand key
// - indirect accesses for branching use the instruction space key
// - address generation in operand space; appended words use instruction key
// - console uses storage address key; stop compare uses stop key when enabled
// - system reset and program load clear all keys and merge bits
// - any interrupt zeroes instruction and second operand keys of that level
// - supervisor call and soft trap: first key takes previous second key
// - machine and program check: first key takes last active processor key
// - trace interrupt: first key takes previous instruction space key
// - level status block store on class interrupt uses key 0
// - active key selects the segmentation register stack used by the translator
// - each priority level owns its own key register
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`include "aks_defines.vh"
`default_nettype none

module aks_key_select (
  input  wire        clk,
  input  wire        rst,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // storage access requests from the sequencer
  input  wire        accReq,
  input  wire [3:0]  accType,
  input  wire [1:0]  accLevel,
  input  wire [2:0]  csKey,
  // key related instructions
  input  wire        opReq,
  input  wire [1:0]  opCode,
  input  wire [1:0]  opLevel,
  input  wire [15:0] opData,
  // interrupts
  input  wire        intReq,
  input  wire [2:0]  intKind,
  input  wire [1:0]  intLevel,
  // system reset or initial program load
  input  wire        clearAll,
  // to the translator
  output reg         keyValid,
  output reg  [2:0]  activeKey,
  output reg  [2:0]  segStack,
  output reg         translatorOn
);

  // bus state
  reg        busPend_q;
  reg        busWrite_q;
  reg [7:0]  busAddr_q;

  // key and console registers
  reg [15:0] levelKey_q [0:3];
  reg [2:0]  sarKey_q;
  reg [2:0]  soaKey_q;
  reg [2:0]  lastProcKey_q;
  reg [3:0]  lastType_q;

  wire       busTake;
  wire       busWr;
  wire [15:0] selReg;
  wire       selMerge;
  wire [2:0] selOp1;
  wire [2:0] selOp2;
  wire [2:0] selIsk;
  reg  [2:0] keyD;
  reg  [31:0] rdD;

  // an address phase is taken only when the bus is ready and the transfer is real
  assign busTake = hsel & htrans[1] & hready;
  assign busWr   = busPend_q & busWrite_q;

  // fields of the requesting level's register
  assign selReg   = levelKey_q[accLevel];
  assign selMerge = selReg[`AKS_MERGE_BIT];
  assign selOp1   = selReg[`AKS_OP1_HI:`AKS_OP1_LO];
  assign selOp2   = selReg[`AKS_OP2_HI:`AKS_OP2_LO];
  assign selIsk   = selReg[`AKS_ISK_HI:`AKS_ISK_LO];

  // bus handshake: one wait state, the data phase completes the transfer
  always @(posedge clk) begin
    if (rst) begin
      busPend_q  <= 1'b0;
      busWrite_q <= 1'b0;
      busAddr_q  <= 8'h00;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (busTake) begin
        busPend_q  <= 1'b1;
        busWrite_q <= hwrite;
        busAddr_q  <= haddr[7:0];
        hreadyout  <= 1'b0;
      end else if (busPend_q) begin
        busPend_q <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= busWrite_q ? 32'h00000000 : rdD;
      end
    end
  end

  // read mux; unmapped words read zero and reserved bits read zero
  always @* begin
    rdD = 32'h00000000;
    case (busAddr_q)
      `AKS_OFF_LEVEL0:  rdD = {16'h0000, levelKey_q[0]};
      `AKS_OFF_LEVEL1:  rdD = {16'h0000, levelKey_q[1]};
      `AKS_OFF_LEVEL2:  rdD = {16'h0000, levelKey_q[2]};
      `AKS_OFF_LEVEL3:  rdD = {16'h0000, levelKey_q[3]};
      `AKS_OFF_SAR_KEY: rdD = {29'h00000000, sarKey_q};
      `AKS_OFF_SOA_KEY: rdD = {29'h00000000, soaKey_q};
      `AKS_OFF_CTRL:    rdD = {31'h00000000, translatorOn};
      `AKS_OFF_STATUS:  rdD = {21'h000000, lastType_q, activeKey, 1'b0, lastProcKey_q};
      default:          rdD = 32'h00000000;
    endcase
  end

  // one update path per level; reset beats interrupt beats instruction beats bus
  genvar lv;
  generate
    for (lv = 0; lv < 4; lv = lv + 1) begin : gLevel
      wire [15:0] cur;
      wire        hitInt;
      wire        hitOp;
      wire        hitBus;
      reg  [2:0]  newOp1;
      assign cur    = levelKey_q[lv];
      assign hitInt = intReq & (intLevel == lv);
      assign hitOp  = opReq & (opLevel == lv);
      assign hitBus = busWr & (busAddr_q == (`AKS_OFF_LEVEL0 + 8'h04 * lv));

      // first operand key left behind by each kind of interrupt
      always @* begin
        case (intKind)
          `AKS_INT_SVC,
          `AKS_INT_SOFTEXC: newOp1 = cur[`AKS_OP2_HI:`AKS_OP2_LO];
          `AKS_INT_MCHECK,
          `AKS_INT_PCHECK:  newOp1 = lastProcKey_q;
          `AKS_INT_TRACE:   newOp1 = cur[`AKS_ISK_HI:`AKS_ISK_LO];
          default:          newOp1 = `AKS_KEY_ZERO;
        endcase
      end

      always @(posedge clk) begin
        if (rst || clearAll) begin
          levelKey_q[lv] <= `AKS_KEYREG_RESET;
        end else if (hitInt) begin
          // merge off, interrupt routines run in space 0
          levelKey_q[lv] <= {1'b0, 4'h0, newOp1, 1'b0, `AKS_KEY_ZERO,
                             1'b0, `AKS_KEY_ZERO};
        end else if (hitOp) begin
          case (opCode)
            `AKS_OP_ENABLE:
              levelKey_q[lv] <= {cur[15] | opData[`AKS_MERGE_BIT], cur[14:0]};
            `AKS_OP_DISABLE:
              levelKey_q[lv] <= {1'b0, cur[14:0]};
            default:
              levelKey_q[lv] <= opData & `AKS_KEYREG_MASK;
          endcase
        end else if (hitBus) begin
          levelKey_q[lv] <= hwdata[15:0] & `AKS_KEYREG_MASK;
        end
      end
    end
  endgenerate

  // console keys and translator state; disable also drops the translator
  always @(posedge clk) begin
    if (rst || clearAll) begin
      sarKey_q     <= `AKS_KEY_ZERO;
      soaKey_q     <= `AKS_KEY_ZERO;
      translatorOn <= 1'b0;
    end else begin
      if (busWr && busAddr_q == `AKS_OFF_SAR_KEY) begin
        sarKey_q <= hwdata[2:0];
      end
      if (busWr && busAddr_q == `AKS_OFF_SOA_KEY) begin
        soaKey_q <= hwdata[2:0];
      end
      if (opReq && opCode == `AKS_OP_ENABLE) begin
        translatorOn <= 1'b1;
      end else if (opReq && opCode == `AKS_OP_DISABLE) begin
        translatorOn <= 1'b0;
      end else if (busWr && busAddr_q == `AKS_OFF_CTRL) begin
        translatorOn <= hwdata[0];
      end
    end
  end

  // active key choice for one access
  always @* begin
    case (accType)
      `AKS_ACC_FETCH:     keyD = selIsk;
      `AKS_ACC_APPENDED:  keyD = selIsk;
      `AKS_ACC_INDIRECT:  keyD = selIsk;
      // operand 1 of a storage-to-storage op, including its address generation
      `AKS_ACC_OPND1:     keyD = selMerge ? selOp2 : selOp1;
      `AKS_ACC_OPND2:     keyD = selOp2;
      `AKS_ACC_DPT_WRITE: keyD = selOp2;
      `AKS_ACC_CYCSTEAL:  keyD = csKey;
      `AKS_ACC_DCB_FETCH: keyD = `AKS_KEY_ZERO;
      `AKS_ACC_CONSOLE:   keyD = sarKey_q;
      // with the translator off the compare is on the raw address, key irrelevant
      `AKS_ACC_STOP_CMP:  keyD = translatorOn ? soaKey_q : `AKS_KEY_ZERO;
      `AKS_ACC_LSB_STORE: keyD = `AKS_KEY_ZERO;
      default:            keyD = selOp2;
    endcase
  end

  // registered answer to the translator; key doubles as the stack number
  always @(posedge clk) begin
    if (rst) begin
      keyValid      <= 1'b0;
      activeKey     <= `AKS_KEY_ZERO;
      segStack      <= `AKS_KEY_ZERO;
      lastProcKey_q <= `AKS_KEY_ZERO;
      lastType_q    <= 4'h0;
    end else begin
      keyValid <= accReq;
      if (clearAll) begin
        lastProcKey_q <= `AKS_KEY_ZERO;
      end else if (accReq && accType <= `AKS_ACC_DPT_WRITE) begin
        // only processor accesses count toward the machine/program check key
        lastProcKey_q <= keyD;
      end
      if (accReq) begin
        activeKey  <= keyD;
        segStack   <= keyD;
        lastType_q <= accType;
      end
    end
  end

endmodule

`default_nettype wire

// ---- sim/aks_assertions.sv ----
// Purpose: port checks for aks_key_select
// Assumes: one clock, synchronous active-high rst
// Notes:   bound onto every key selector instance
`default_nettype none
module aks_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       accReq,
  input wire logic [3:0] accType,
  input wire logic [2:0] csKey,
  input wire logic       clearAll,
  input wire logic       keyValid,
  input wire logic [2:0] activeKey,
  input wire logic [2:0] segStack
);
  timeunit 1ns;
  timeprecision 1ps;
  // single domain, so clock and reset are stated once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // answer timing and holding of the key
  a_answer_next: assert property (accReq |=> keyValid)
    else $error("no answer");
  a_no_stray: assert property (!accReq |=> !keyValid)
    else $error("stray answer");
  a_stack_is_key: assert property (keyValid |-> segStack == activeKey)
    else $error("stack differs from key");
  a_key_held: assert property (!accReq |=> $stable(activeKey))
    else $error("key moved");
  // supplied and zero keys for i/o and status store traffic
  a_steal_key: assert property (accReq && accType == 4'h6 |=> activeKey == $past(csKey))
    else $error("steal key wrong");
  a_block_zero: assert property (accReq && accType == 4'h7 |=> activeKey == 3'h0)
    else $error("block fetch key");
  a_status_zero: assert property (accReq && accType == 4'hA |=> activeKey == 3'h0)
    else $error("status store key");
  // a clear must be seen by the very next fetch
  a_clear_fetch: assert property (
    $past(clearAll) && accReq && accType == 4'h0 |=> activeKey == 3'h0)
    else $error("key survived clear");
endmodule
bind aks_key_select aks_checker u_chk (.clk(clk), .rst(rst), .accReq(accReq),
  .accType(accType), .csKey(csKey), .clearAll(clearAll), .keyValid(keyValid),
  .activeKey(activeKey), .segStack(segStack));
`default_nettype wire

// ---- sim/aks_xlat_model.sv ----
// Purpose: translator side, picks a segment stack per access
// Assumes: keys arrive with a one-cycle valid
// Notes:   stack number is what the bench compares
`default_nettype none
module aks_xlat_model (
  input  wire logic       clk,
  input  wire logic       keyValid,
  input  wire logic [2:0] segStack,
  output var  logic       stackSel,
  output var  logic [2:0] stackNum
);
  timeunit 1ns;
  timeprecision 1ps;
  // stack choice latched per access, as the translator would
  always @(posedge clk) begin
    stackSel <= keyValid;
    stackNum <= segStack;
  end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for aks_key_select
// Assumes: 200 MHz clock, synchronous active-high reset
// Notes:   expected keys come from a local copy of the level registers
`include "aks_defines.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = '0, rst = '1, hwrite = '0, accReq = '0, opReq = '0, intReq = '0;
  logic        clearAll = '0, rdPh = '0, xon = '0;
  logic [1:0]  htrans = '0, accLevel = '0, opCode = '0, opLevel = '0, intLevel = '0;
  logic [2:0]  csKey = '0, intKind = '0, sarK = '0, soaK = '0, lpk = '0, keyQ[$];
  logic [3:0]  accType = '0;
  logic [15:0] opData = '0, kr[4];
  logic [31:0] haddr = '0, hwdata = '0, rdQ[$];
  int          fail_count = 0, checks_done = 0, cyc = 0;
  wire logic        hreadyout, keyValid, stackSel, hresp, translatorOn;
  wire logic [2:0]  activeKey, segStack, stackNum;
  wire logic [31:0] hrdata;

  always #2.5 clk = ~clk;

  aks_key_select dut (.clk(clk), .rst(rst), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hresp(hresp),
    .hreadyout(hreadyout), .hrdata(hrdata), .accReq(accReq), .accType(accType),
    .accLevel(accLevel), .csKey(csKey), .opReq(opReq), .opCode(opCode), .opLevel(opLevel),
    .opData(opData), .intReq(intReq), .intKind(intKind), .intLevel(intLevel),
    .clearAll(clearAll), .keyValid(keyValid), .activeKey(activeKey), .segStack(segStack),
    .translatorOn(translatorOn));
  aks_xlat_model xlat (.clk(clk), .keyValid(keyValid), .segStack(segStack),
    .stackSel(stackSel), .stackNum(stackNum));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  // results sampled mid-cycle, where registered outputs are settled
  always @(negedge clk) begin
    if (stackSel === 1'h1) chk("stack", {29'h0, keyQ.pop_front()}, {29'h0, stackNum});
    if (rdPh && hreadyout === 1'h1) chk("hrdata", rdQ.pop_front(), hrdata);
    if (rdPh && hreadyout === 1'h1) chk("hresp", 32'h0, {31'h0, hresp});
  end
  // one word transfer, ready sampled at the rising edge that ends each phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    rdPh = !w;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rdPh = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic op(input logic [1:0] c, input logic [1:0] lv, input logic [15:0] d);
    if (c == 2'h0) kr[lv][15] = kr[lv][15] | d[15];
    else if (c == 2'h1) kr[lv][15] = 1'h0;
    else kr[lv] = d & `AKS_KEYREG_MASK;
    if (c < 2'h2) xon = (c == 2'h0);
    opReq <= 1'h1;
    opCode <= c;
    opLevel <= lv;
    opData <= d;
    @(posedge clk);
    opReq <= 1'h0;
    @(negedge clk);
    chk("xlat_on", {31'h0, xon}, {31'h0, translatorOn});
    @(posedge clk);
  endtask
  // level load by bus when h is zero, otherwise by instruction h
  task automatic load(input logic [1:0] h, input logic [1:0] lv, input logic [15:0] d);
    if (h != 2'h0) op(h, lv, d);
    else begin
      kr[lv] = d & `AKS_KEYREG_MASK;
      bus(1'h1, {4'h0, lv, 2'h0}, {16'h0, d});
    end
  endtask
  task automatic irq(input logic [2:0] k, input logic [1:0] lv);
    logic [2:0] o1;
    o1 = (k inside {3'h1, 3'h4}) ? kr[lv][6:4] : (k inside {3'h2, 3'h3}) ? lpk
       : (k == 3'h5) ? kr[lv][2:0] : 3'h0;
    kr[lv] = {5'h0, o1, 8'h0};
    intReq <= 1'h1;
    intKind <= k;
    intLevel <= lv;
    @(posedge clk);
    intReq <= 1'h0;
    @(posedge clk);
  endtask
  // back-to-back accesses of types 0 to n-1, expected key noted first
  task automatic sweep(input logic [1:0] lv, input int n);
    logic [2:0] e;
    logic [2:0] cs;
    for (int t = 0; t < n; t++) begin
      cs = 3'($urandom);
      case (t)
        0, 1, 4: e = kr[lv][2:0];
        2: e = kr[lv][15] ? kr[lv][6:4] : kr[lv][10:8];
        6: e = cs;
        7, 10: e = 3'h0;
        8: e = sarK;
        9: e = xon ? soaK : 3'h0;
        default: e = kr[lv][6:4];
      endcase
      if (t < 6) lpk = e;
      keyQ.push_back(e);
      accReq <= 1'h1;
      accType <= 4'(t);
      accLevel <= lv;
      csKey <= cs;
      @(posedge clk);
    end
    accReq <= 1'h0;
    @(posedge clk);
  endtask

  initial begin
    kr = '{default: 16'h0};
    void'($urandom(67639));
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
    bus(1'h1, 8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0);
    sarK = 3'($urandom);
    soaK = 3'($urandom);
    bus(1'h1, 8'h10, {29'h0, sarK});
    bus(1'h1, 8'h14, {29'h0, soaK});
    // loads by bus and by both instructions, then merge on and off
    for (int p = 0; p < 4; p++) begin
      if (p == 2) op(2'h0, 2'h1, 16'h8000);
      if (p == 3) op(2'h1, 2'h1, 16'h0);
      for (int lv = 0; lv < 4; lv++) begin
        if (p < 2) load(p == 0 ? 2'h0 : {1'h1, lv[0]}, lv[1:0], 16'($urandom));
        rd({4'h0, lv[1:0], 2'h0}, {16'h0, kr[lv]});
        sweep(lv[1:0], 16);
      end
    end
    // every interrupt kind after a recent processor access
    for (int k = 0; k < 8; k++) begin
      load(2'h3, k[1:0], 16'($urandom) | 16'h8000);
      sweep(k[1:0], 6);
      irq(k[2:0], k[1:0]);
      rd({4'h0, k[1:0], 2'h0}, {16'h0, kr[k[1:0]]});
      sweep(k[1:0], 4);
    end
    clearAll <= 1'h1;
    @(posedge clk);
    clearAll <= 1'h0;
    kr = '{default: 16'h0};
    xon = 1'h0;
    sweep(2'h3, 3);
    for (int lv = 0; lv < 4; lv++) rd(8'(lv * 4), 32'h0);
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
endmodule
`default_nettype wire
